// [rtl/dpal_top.sv]
// dual process alarm logic: registers, rate window, latching, power-up, interrupts
`timescale 1ns/100ps
`default_nettype none
module dpal_top #(
  parameter int NA = 2,
  parameter int SEC_CYCLES = dpal_pkg::SEC_CYCLES,
  parameter logic signed [dpal_pkg::VW-1:0] RANGE_LO_DEF = 18'h00000,
  parameter logic signed [dpal_pkg::VW-1:0] RANGE_HI_DEF = 18'h003e8,
  parameter logic [1:0] PU_MODE_A0 = dpal_pkg::PU_NORMAL,
  parameter logic [1:0] PU_MODE_A1 = dpal_pkg::PU_NORMAL
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic signed [dpal_pkg::VW-1:0] process_value_in,
  input wire logic signed [dpal_pkg::VW-1:0] reference_indication_in,
  input wire logic local_mode_in,
  output logic [1:0] alarm_out,
  output logic [1:0] relay_out,
  output logic irq_out
);
  localparam int VW = dpal_pkg::VW;
  localparam int HW = dpal_pkg::HW;
  localparam int TW = dpal_pkg::TW;
  localparam int CW = dpal_pkg::SEC_CW;

  function automatic logic signed [VW-1:0] clamp(input logic signed [VW-1:0] v,
                                                   input logic signed [VW-1:0] lo,
                                                   input logic signed [VW-1:0] hi);
    if (v < lo) begin
      clamp = lo;
    end else if (v > hi) begin
      clamp = hi;
    end else begin
      clamp = v;
    end
  endfunction

  function automatic logic kind_ok(input logic [2:0] k, input logic [1:0] ind);
    if (k > dpal_pkg::DPAL_KIND_DEV) begin
      kind_ok = 1'b0;
    end else if (k == dpal_pkg::DPAL_KIND_BAND || k == dpal_pkg::DPAL_KIND_DEV) begin
      kind_ok = (ind == dpal_pkg::IND_REF);
    end else begin
      kind_ok = 1'b1;
    end
  endfunction

  function automatic logic alm_hit(input logic [7:0] a, input int idx, input logic [4:0] off);
    alm_hit = (a[7:5] == 3'(dpal_pkg::A_ALM_BLK0 + 3'(idx))) && (a[4:0] == off);
  endfunction

  // global configuration
  logic [1:0] ind_ff;
  logic signed [VW-1:0] range_lo_ff, range_hi_ff;
  logic [TW-1:0] rate_time_ff;
  logic [dpal_pkg::IRQ_W-1:0] irq_stat_ff, irq_en_ff, irq_ev;
  logic [31:0] nxt_rdata;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ind_ff <= dpal_pkg::IND_NONE;
    end else if (wr_in && addr_in == dpal_pkg::A_CTRL && wdata_in[1:0] != 2'h3) begin
      ind_ff <= wdata_in[1:0];
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      range_lo_ff <= RANGE_LO_DEF;
      range_hi_ff <= RANGE_HI_DEF;
    end else if (wr_in && addr_in == dpal_pkg::A_RANGE_LO) begin
      range_lo_ff <= clamp(wdata_in[VW-1:0], dpal_pkg::VAL_MIN, range_hi_ff);
    end else if (wr_in && addr_in == dpal_pkg::A_RANGE_HI) begin
      range_hi_ff <= clamp(wdata_in[VW-1:0], range_lo_ff, dpal_pkg::VAL_MAX);
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rate_time_ff <= dpal_pkg::RATE_DEF;
    end else if (wr_in && addr_in == dpal_pkg::A_RATE) begin
      if (wdata_in[31:TW] != '0 || wdata_in[TW-1:0] > dpal_pkg::RATE_MAX) begin
        rate_time_ff <= dpal_pkg::RATE_MAX;
      end else if (wdata_in[TW-1:0] < dpal_pkg::RATE_MIN) begin
        rate_time_ff <= dpal_pkg::RATE_MIN;
      end else begin
        rate_time_ff <= wdata_in[TW-1:0];
      end
    end
  end

  // shared rate window: seconds counter and window counter
  logic [CW-1:0] sec_cnt_ff;
  logic [TW-1:0] win_cnt_ff;
  logic signed [VW-1:0] sample_ff;
  logic signed [VW:0] delta_ff;
  logic sec_tick, win_end;

  assign sec_tick = (sec_cnt_ff == CW'(SEC_CYCLES - 1));
  assign win_end = sec_tick && (win_cnt_ff + 12'h001 >= rate_time_ff);

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sec_cnt_ff <= '0;
    end else begin
      sec_cnt_ff <= sec_tick ? '0 : sec_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      win_cnt_ff <= '0;
      sample_ff <= '0;
      delta_ff <= '0;
    end else if (win_end) begin
      win_cnt_ff <= '0;
      sample_ff <= process_value_in;
      delta_ff <= {process_value_in[VW-1], process_value_in} - {sample_ff[VW-1], sample_ff};
    end else if (wr_in && addr_in == dpal_pkg::A_RATE) begin
      win_cnt_ff <= '0;
    end else if (sec_tick) begin
      win_cnt_ff <= win_cnt_ff + 12'h001;
    end
  end

  // per-alarm state
  dpal_pkg::dpal_kind_t kind_ff [NA];
  dpal_pkg::dpal_kind_t eff_kind [NA];
  logic signed [VW-1:0] thr_ff [NA];
  logic [HW-1:0] hyst_ff [NA];
  logic [dpal_pkg::OPT_W-1:0] opts_ff [NA];
  logic [71:0] msg_ff [NA];
  logic [NA-1:0] cond_ff, nxt_cond, latch_ff, nxt_latch, force_ff, sup_ff;
  logic [NA-1:0] alarm_ff, nxt_alarm, relay_ff, ack_req, ack_ok, gated;
  for (genvar i = 0; i < NA; i++) begin : g_alm
    localparam logic [1:0] PU_RST = (i == 0) ? PU_MODE_A0 : PU_MODE_A1;

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        kind_ff[i] <= dpal_pkg::DPAL_KIND_OFF;
      end else if (wr_in && alm_hit(addr_in, i, dpal_pkg::O_KIND) && kind_ok(wdata_in[2:0], ind_ff)) begin
        kind_ff[i] <= dpal_pkg::dpal_kind_t'(wdata_in[2:0]);
      end
    end

    always_comb begin
      eff_kind[i] = kind_ff[i];
      if ((kind_ff[i] == dpal_pkg::DPAL_KIND_BAND || kind_ff[i] == dpal_pkg::DPAL_KIND_DEV)
          && ind_ff != dpal_pkg::IND_REF) begin
        eff_kind[i] = dpal_pkg::DPAL_KIND_OFF;
      end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        thr_ff[i] <= (i == 0) ? RANGE_LO_DEF : RANGE_HI_DEF;
      end else if (wr_in && alm_hit(addr_in, i, dpal_pkg::O_THR)) begin
        if (kind_ff[i] == dpal_pkg::DPAL_KIND_RATE) begin
          thr_ff[i] <= clamp(wdata_in[VW-1:0], dpal_pkg::VAL_MIN, dpal_pkg::VAL_MAX);
        end else begin
          thr_ff[i] <= clamp(wdata_in[VW-1:0], range_lo_ff, range_hi_ff);
        end
      end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        hyst_ff[i] <= dpal_pkg::HYST_DEF;
      end else if (wr_in && alm_hit(addr_in, i, dpal_pkg::O_HYST)) begin
        if (wdata_in[31:HW] != '0 || wdata_in[HW-1:0] > dpal_pkg::HYST_MAX) begin
          hyst_ff[i] <= dpal_pkg::HYST_MAX;
        end else if (wdata_in[HW-1:0] < dpal_pkg::HYST_MIN) begin
          hyst_ff[i] <= dpal_pkg::HYST_MIN;
        end else begin
          hyst_ff[i] <= wdata_in[HW-1:0];
        end
      end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        opts_ff[i] <= {PU_RST, 3'h0};
      end else if (wr_in && alm_hit(addr_in, i, dpal_pkg::O_OPTS)) begin
        opts_ff[i] <= {(wdata_in[4:3] == 2'h3) ? opts_ff[i][4:3] : wdata_in[4:3], wdata_in[2:0]};
      end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        msg_ff[i] <= (i == 0) ? dpal_pkg::MSG_DEF0 : dpal_pkg::MSG_DEF1;
      end else if (wr_in && alm_hit(addr_in, i, dpal_pkg::O_MSG0)) begin
        msg_ff[i][71:48] <= wdata_in[23:0];
      end else if (wr_in && alm_hit(addr_in, i, dpal_pkg::O_MSG1)) begin
        msg_ff[i][47:24] <= wdata_in[23:0];
      end else if (wr_in && alm_hit(addr_in, i, dpal_pkg::O_MSG2)) begin
        msg_ff[i][23:0] <= wdata_in[23:0];
      end
    end

    dpal_eval #(.VW(VW), .HW(HW)) u_eval (
      .kind_in(eff_kind[i]),
      .thr_in(thr_ff[i]),
      .hyst_in(hyst_ff[i]),
      .pv_in(process_value_in),
      .ref_in(reference_indication_in),
      .delta_in(delta_ff),
      .local_in(local_mode_in),
      .cond_in(cond_ff[i]),
      .nxt_cond_out(nxt_cond[i])
    );

    assign ack_req[i] = wr_in && alm_hit(addr_in, i, dpal_pkg::O_ACK) && wdata_in[0];
    assign ack_ok[i] = ack_req[i] && !(opts_ff[i][dpal_pkg::OPT_ACK_DIS] && cond_ff[i]);
    assign gated[i] = nxt_cond[i] && !sup_ff[i];

    always_comb begin
      nxt_latch[i] = latch_ff[i];
      if (eff_kind[i] == dpal_pkg::DPAL_KIND_OFF || opts_ff[i][dpal_pkg::OPT_NO_LATCH]) begin
        nxt_latch[i] = 1'b0;
      end else if (gated[i]) begin
        nxt_latch[i] = 1'b1;
      end else if (ack_ok[i]) begin
        nxt_latch[i] = 1'b0;
      end
      nxt_alarm[i] = (eff_kind[i] != dpal_pkg::DPAL_KIND_OFF) && (gated[i] || nxt_latch[i] || force_ff[i]);
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        force_ff[i] <= (PU_RST == dpal_pkg::PU_FORCED);
      end else if (ack_ok[i]) begin
        force_ff[i] <= 1'b0;
      end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        sup_ff[i] <= (PU_RST == dpal_pkg::PU_DELAYED);
      end else if (eff_kind[i] != dpal_pkg::DPAL_KIND_OFF && !nxt_cond[i]) begin
        sup_ff[i] <= 1'b0;
      end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        cond_ff[i] <= 1'b0;
        latch_ff[i] <= 1'b0;
        alarm_ff[i] <= 1'b0;
        relay_ff[i] <= 1'b0;
      end else begin
        cond_ff[i] <= nxt_cond[i];
        latch_ff[i] <= nxt_latch[i];
        alarm_ff[i] <= nxt_alarm[i];
        relay_ff[i] <= nxt_alarm[i] ^ opts_ff[i][dpal_pkg::OPT_RELAY_OFF];
      end
    end
  end

  // interrupts: raise and clear events, set wins over clear
  assign irq_ev = {~nxt_alarm & alarm_ff, nxt_alarm & ~alarm_ff};

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_stat_ff <= '0;
    end else if (wr_in && addr_in == dpal_pkg::A_IRQ_CLR) begin
      irq_stat_ff <= (irq_stat_ff & ~wdata_in[dpal_pkg::IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat_ff <= irq_stat_ff | irq_ev;
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_en_ff <= '0;
    end else if (wr_in && addr_in == dpal_pkg::A_IRQ_EN) begin
      irq_en_ff <= wdata_in[dpal_pkg::IRQ_W-1:0];
    end
  end

  // read mux; data stand one cycle after the strobe only
  always_comb begin
    nxt_rdata = '0;
    case (addr_in)
      dpal_pkg::A_CTRL: nxt_rdata = {30'h0, ind_ff};
      dpal_pkg::A_RANGE_LO: nxt_rdata = 32'(range_lo_ff);
      dpal_pkg::A_RANGE_HI: nxt_rdata = 32'(range_hi_ff);
      dpal_pkg::A_RATE: nxt_rdata = {20'h0, rate_time_ff};
      dpal_pkg::A_STATUS: nxt_rdata = {24'h0, force_ff, sup_ff, cond_ff, alarm_ff};
      dpal_pkg::A_IRQ_STAT: nxt_rdata = {28'h0, irq_stat_ff};
      dpal_pkg::A_IRQ_EN: nxt_rdata = {28'h0, irq_en_ff};
      default: begin
        for (int j = 0; j < NA; j++) begin
          if (alm_hit(addr_in, j, dpal_pkg::O_KIND)) nxt_rdata = {29'h0, kind_ff[j]};
          if (alm_hit(addr_in, j, dpal_pkg::O_THR)) nxt_rdata = 32'(thr_ff[j]);
          if (alm_hit(addr_in, j, dpal_pkg::O_HYST)) nxt_rdata = {18'h0, hyst_ff[j]};
          if (alm_hit(addr_in, j, dpal_pkg::O_OPTS)) nxt_rdata = {27'h0, opts_ff[j]};
          if (alm_hit(addr_in, j, dpal_pkg::O_MSG0)) nxt_rdata = {8'h0, msg_ff[j][71:48]};
          if (alm_hit(addr_in, j, dpal_pkg::O_MSG1)) nxt_rdata = {8'h0, msg_ff[j][47:24]};
          if (alm_hit(addr_in, j, dpal_pkg::O_MSG2)) nxt_rdata = {8'h0, msg_ff[j][23:0]};
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= rd_in ? nxt_rdata : '0;
    end
  end

  assign alarm_out = alarm_ff;
  assign relay_out = relay_ff;
  assign irq_out = |(irq_stat_ff & irq_en_ff);
  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_ack_refused;
    ack_req[0] && opts_ff[0][dpal_pkg::OPT_ACK_DIS] && cond_ff[0] && latch_ff[0]
    && !opts_ff[0][dpal_pkg::OPT_NO_LATCH] && eff_kind[0] != dpal_pkg::DPAL_KIND_OFF;
  endsequence
  sequence s_local_hold;
    eff_kind[1] == dpal_pkg::DPAL_KIND_LOCAL && local_mode_in && !sup_ff[1];
  endsequence
  a_off_quiet: assert property (eff_kind[0] == dpal_pkg::DPAL_KIND_OFF |=> !alarm_ff[0])
    else $error("off alarm asserted");
  a_local_follow: assert property (s_local_hold |=> alarm_ff[1])
    else $error("local alarm missed");
  a_rate_window: assert property (win_cnt_ff < rate_time_ff && rate_time_ff <= dpal_pkg::RATE_MAX)
    else $error("rate window out of bounds");
  a_thr_bounds: assert property (thr_ff[1] >= dpal_pkg::VAL_MIN && thr_ff[1] <= dpal_pkg::VAL_MAX)
    else $error("threshold out of limits");
  a_relay_polarity: assert property (relay_out[0] == (alarm_ff[0] ^ $past(opts_ff[0][0])))
    else $error("relay polarity wrong");
  a_ack_refused: assert property (s_ack_refused |=> latch_ff[0])
    else $error("refused ack cleared latch");
  a_nolatch_follow: assert property (opts_ff[0][1] && !force_ff[0] && !sup_ff[0]
                                     && eff_kind[0] != dpal_pkg::DPAL_KIND_OFF
                                     |=> alarm_ff[0] == cond_ff[0])
    else $error("non-latching alarm not following");
  a_delay_sup: assert property (sup_ff[1] && !force_ff[1] && !latch_ff[1] |=> !alarm_ff[1])
    else $error("suppressed alarm asserted");
  a_irq_sticky: assert property (irq_stat_ff[0] && !(wr_in && addr_in == dpal_pkg::A_IRQ_CLR) |=> irq_stat_ff[0])
    else $error("status bit lost");
  a_band_gate: assert property (ind_ff != dpal_pkg::IND_REF |-> eff_kind[0] != dpal_pkg::DPAL_KIND_BAND)
    else $error("band kind without reference");
endmodule
`default_nettype wire

// [rtl/dpal_pkg.sv]
// constants and types shared by the dual process alarm logic
package dpal_pkg;

  // value width: signed engineering units, -9999 .. 99999
  localparam int VW = 18;
  localparam int HW = 14;
  localparam int TW = 12;

  // alarm kinds
  typedef enum logic [2:0] {
    DPAL_KIND_OFF   = 3'h0,
    DPAL_KIND_LOCAL = 3'h1,
    DPAL_KIND_HIGH  = 3'h2,
    DPAL_KIND_LOW   = 3'h3,
    DPAL_KIND_RATE  = 3'h4,
    DPAL_KIND_BAND  = 3'h5,
    DPAL_KIND_DEV   = 3'h6
  } dpal_kind_t;

  // value limits
  localparam logic signed [VW-1:0] VAL_MIN = 18'h3d8f1;
  localparam logic signed [VW-1:0] VAL_MAX = 18'h1869f;
  localparam logic [HW-1:0] HYST_MIN = 14'h0001;
  localparam logic [HW-1:0] HYST_MAX = 14'h270f;
  localparam logic [HW-1:0] HYST_DEF = 14'h0002;
  localparam logic [TW-1:0] RATE_MIN = 12'h001;
  localparam logic [TW-1:0] RATE_MAX = 12'he10;
  localparam logic [TW-1:0] RATE_DEF = 12'h005;

  // timing: one second in clock cycles
  localparam int CLK_PERIOD_NS = 100;
  localparam int SEC_NS = 1000000000;
  localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
  localparam int SEC_CW = 24;

  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_RANGE_LO = 8'h04;
  localparam logic [7:0] A_RANGE_HI = 8'h08;
  localparam logic [7:0] A_RATE = 8'h0c;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_IRQ_STAT = 8'h14;
  localparam logic [7:0] A_IRQ_CLR = 8'h18;
  localparam logic [7:0] A_IRQ_EN = 8'h1c;
  // per alarm block: base 0x20 for alarm 0, 0x40 for alarm 1
  localparam logic [2:0] A_ALM_BLK0 = 3'h1;
  localparam logic [4:0] O_KIND = 5'h00;
  localparam logic [4:0] O_THR = 5'h04;
  localparam logic [4:0] O_HYST = 5'h08;
  localparam logic [4:0] O_OPTS = 5'h0c;
  localparam logic [4:0] O_MSG0 = 5'h10;
  localparam logic [4:0] O_MSG1 = 5'h14;
  localparam logic [4:0] O_MSG2 = 5'h18;
  localparam logic [4:0] O_ACK = 5'h1c;

  // indication select in control register
  localparam logic [1:0] IND_NONE = 2'h0;
  localparam logic [1:0] IND_REF = 2'h1;
  localparam logic [1:0] IND_VALVE = 2'h2;

  // option bits
  localparam int OPT_RELAY_OFF = 0;
  localparam int OPT_NO_LATCH = 1;
  localparam int OPT_ACK_DIS = 2;
  localparam int OPT_PU_LSB = 3;
  localparam int OPT_W = 5;
  localparam logic [1:0] PU_NORMAL = 2'h0;
  localparam logic [1:0] PU_FORCED = 2'h1;
  localparam logic [1:0] PU_DELAYED = 2'h2;

  // interrupt layout: [1:0] alarm raised, [3:2] alarm cleared
  localparam int IRQ_W = 4;

  // default nine-character messages, ascii
  localparam logic [71:0] MSG_DEF0 = 72'h414c41524d20312020;
  localparam logic [71:0] MSG_DEF1 = 72'h414c41524d20322020;

endpackage

// [rtl/dpal_eval.sv]
// per-alarm condition evaluator with hysteresis
`timescale 1ns/100ps
`default_nettype none
module dpal_eval #(
  parameter int VW = 18,
  parameter int HW = 14
) (
  input wire dpal_pkg::dpal_kind_t kind_in,
  input wire logic signed [VW-1:0] thr_in,
  input wire logic [HW-1:0] hyst_in,
  input wire logic signed [VW-1:0] pv_in,
  input wire logic signed [VW-1:0] ref_in,
  input wire logic signed [VW:0] delta_in,
  input wire logic local_in,
  input wire logic cond_in,
  output logic nxt_cond_out
);
  localparam int XW = VW + 3;
  logic signed [XW-1:0] pv_x, ref_x, thr_x, hyst_x, diff, meas;
  logic low_sense;

  assign pv_x = {{3{pv_in[VW-1]}}, pv_in};
  assign ref_x = {{3{ref_in[VW-1]}}, ref_in};
  assign thr_x = {{3{thr_in[VW-1]}}, thr_in};
  assign hyst_x = XW'({1'b0, hyst_in});
  assign diff = pv_x - ref_x;

  always_comb begin
    meas = pv_x;
    low_sense = 1'b0;
    nxt_cond_out = 1'b0;
    case (kind_in)
      dpal_pkg::DPAL_KIND_OFF: nxt_cond_out = 1'b0;
      dpal_pkg::DPAL_KIND_LOCAL: nxt_cond_out = local_in;
      dpal_pkg::DPAL_KIND_LOW: low_sense = 1'b1;
      dpal_pkg::DPAL_KIND_RATE: meas = {{2{delta_in[VW]}}, delta_in};
      dpal_pkg::DPAL_KIND_DEV: meas = diff;
      dpal_pkg::DPAL_KIND_BAND: meas = diff[XW-1] ? -diff : diff;
      default: meas = pv_x;
    endcase
    if (kind_in != dpal_pkg::DPAL_KIND_OFF && kind_in != dpal_pkg::DPAL_KIND_LOCAL) begin
      if (low_sense) begin
        nxt_cond_out = cond_in ? !(meas > thr_x + hyst_x) : (meas < thr_x);
      end else begin
        nxt_cond_out = cond_in ? !(meas < thr_x - hyst_x) : (meas > thr_x);
      end
    end
  end
endmodule
`default_nettype wire

// [tb/dpal_tb_top.sv]
// self-checking testbench for the dual process alarm logic
`timescale 1ns/100ps
`default_nettype none
module dpal_tb_top;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rdata_out;
  logic signed [dpal_pkg::VW-1:0] process_value_in = 18'h0;
  logic signed [dpal_pkg::VW-1:0] reference_indication_in = 18'h0;
  logic local_mode_in = 1'b0;
  logic [1:0] alarm_out;
  logic [1:0] relay_out;
  logic irq_out;
  int err_count = 0;
  int samples_checked = 0;
  logic [31:0] rv;
  logic [31:0] rv_pu;
  logic [31:0] rdata_pu;
  logic [1:0] alarm_pu;
  logic [1:0] relay_pu;
  logic irq_pu;
  logic c;
  int v;

  always #50 mclk_in = ~mclk_in;

  dpal_top #(.SEC_CYCLES(10)) dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .process_value_in(process_value_in), .reference_indication_in(reference_indication_in),
    .local_mode_in(local_mode_in), .alarm_out(alarm_out), .relay_out(relay_out), .irq_out(irq_out));

  // second instance with forced power-up on alarm 0 and delayed power-up on alarm 1
  dpal_top #(.SEC_CYCLES(10), .PU_MODE_A0(dpal_pkg::PU_FORCED), .PU_MODE_A1(dpal_pkg::PU_DELAYED)) dut_pu (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_pu), .process_value_in(process_value_in),
    .reference_indication_in(reference_indication_in), .local_mode_in(local_mode_in), .alarm_out(alarm_pu),
    .relay_out(relay_pu), .irq_out(irq_pu));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    rv = rdata_out;
    rv_pu = rdata_pu;
  endtask

  task automatic go(input int p, input int r, input logic l);
    @(posedge mclk_in);
    process_value_in <= p[17:0];
    reference_indication_in <= r[17:0];
    local_mode_in <= l;
    @(posedge mclk_in);
    #1;
  endtask

  task automatic settle;
    @(posedge mclk_in);
    #1;
  endtask

  // high kind with threshold 500 and hysteresis 2
  function automatic logic hi_cond(input int x, input logic prev);
    return (x > 500) ? 1'b1 : ((x < 498) ? 1'b0 : prev);
  endfunction

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #3000000;
    err_count++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h68dc3ce1));
    repeat (6) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    rd(8'h20); chk(rv, 32'h0);
    rd(8'h28); chk(rv, 32'h2);
    rd(8'h0c); chk(rv, 32'h5);
    rd(8'h30); chk(rv, 32'h414c41);
    rd(8'h58); chk(rv, 32'h322020);
    rd(8'h24); chk(rv, 32'h0);
    rd(8'h44); chk(rv, 32'h3e8);
    rd(8'h2c); chk(rv, 32'h0);
    chk(rv_pu, 32'h8);
    rd(8'hfc); chk(rv, 32'h0);
    rd(8'h10); chk(rv_pu, 32'h60);
    go(5000, 0, 1'b1); chk(alarm_out, 32'h0);
    chk(relay_out, 32'h0);
    chk(alarm_pu, 32'h0);
    wr(8'h20, 32'h5); rd(8'h20); chk(rv, 32'h0);
    wr(8'h00, 32'h3); rd(8'h00); chk(rv, 32'h0);
    wr(8'h00, 32'h1); wr(8'h24, 32'h64); wr(8'h2c, 32'h2); wr(8'h20, 32'h6);
    rd(8'h20); chk(rv, 32'h6);
    go(5000, 0, 1'b0); chk(alarm_out[0], 32'h1);
    go(5000, 4950, 1'b0); chk(alarm_out[0], 32'h0);
    chk(alarm_pu[0], 32'h1);
    go(5000, 5200, 1'b0); chk(alarm_out[0], 32'h0);
    wr(8'h20, 32'h5); settle(); chk(alarm_out[0], 32'h1);
    wr(8'h2c, 32'h0); wr(8'h20, 32'h2); go(0, 0, 1'b0); wr(8'h3c, 32'h1);
    wr(8'h18, 32'hf); wr(8'h1c, 32'h1);
    settle(); chk(alarm_pu[0], 32'h0);
    go(101, 0, 1'b0); chk(alarm_out[0], 32'h1);
    chk(irq_out, 32'h1);
    wr(8'h1c, 32'h0); settle(); chk(irq_out, 32'h0);
    go(99, 0, 1'b0); chk(alarm_out[0], 32'h1);
    go(50, 0, 1'b0); chk(alarm_out[0], 32'h1);
    rd(8'h10); chk(rv & 32'h5, 32'h1);
    wr(8'h1c, 32'h4); wr(8'h3c, 32'h1); settle(); chk(alarm_out[0], 32'h0);
    chk(irq_out, 32'h1);
    wr(8'h18, 32'hf); settle(); chk(irq_out, 32'h0);
    wr(8'h2c, 32'h4); go(200, 0, 1'b0); wr(8'h3c, 32'h1); settle();
    chk(alarm_out[0], 32'h1);
    go(50, 0, 1'b0); wr(8'h3c, 32'h1); settle(); chk(alarm_out[0], 32'h0);
    wr(8'h4c, 32'h3); wr(8'h44, 32'h64); wr(8'h40, 32'h3);
    go(99, 0, 1'b0); chk(alarm_out[1], 32'h1);
    chk(alarm_pu[1], 32'h0);
    chk(relay_out[1], 32'h0);
    go(101, 0, 1'b0); chk(alarm_out[1], 32'h1);
    go(103, 0, 1'b0); chk(alarm_out[1], 32'h0);
    chk(relay_out[1], 32'h1);
    wr(8'h40, 32'h1); go(103, 0, 1'b1); chk(alarm_out[1], 32'h1);
    chk(alarm_pu[1], 32'h1);
    go(103, 0, 1'b0); chk(alarm_out[1], 32'h0);
    wr(8'h2c, 32'h2); wr(8'h3c, 32'h1); wr(8'h24, 32'h1f4); go(0, 0, 1'b0);
    c = 1'b0;
    for (int i = 0; i < 200; i++) begin
      v = (i % 50 == 0) ? 498 : $urandom_range(510, 490);
      c = hi_cond(v, c);
      go(v, 0, 1'b0);
      chk(alarm_out[0], c);
      chk(relay_out[0], c);
    end
    wr(8'h54, 32'h4d5347); rd(8'h54); chk(rv, 32'h4d5347);
    wr(8'h0c, 32'h1); rd(8'h0c); chk(rv, 32'h1);
    wr(8'h44, 32'hc350); rd(8'h44); chk(rv, 32'h3e8);
    wr(8'h40, 32'h4); wr(8'h44, 32'h3d8f0); rd(8'h44); chk(rv, 32'hffffd8f1);
    wr(8'h44, 32'h32); wr(8'h48, 32'h0); rd(8'h48); chk(rv, 32'h1);
    wr(8'h48, 32'h10000); rd(8'h48); chk(rv, 32'h270f);
    wr(8'h48, 32'h2); go(0, 0, 1'b0);
    repeat (25) settle();
    chk(alarm_out[1], 32'h0);
    // a step of 1000 gives one window of 10 cycles with the rate alarm set
    go(1000, 0, 1'b0);
    v = 0;
    repeat (25) begin
      settle();
      v += alarm_out[1];
    end
    chk(v, 32'ha);
    print_verdict();
  end
endmodule
`default_nettype wire
